// ===== hdl/aoc_output_stage.v
// sample output stage: latches three channel words, checksums them, selects temperature source
//
// Behaviour
// - each channel result is a 24-bit two's-complement signed code.
// - codes clamp between 0x800000 and 0x7FFFFF.
// - the three sample registers refresh once per output cycle set by rate field.
// - output cycle is 512, 1024, 2048 or 4096 input clocks for rate 0..3.
// - a new 16-bit checksum is computed over the three samples each output cycle.
// - checksum takes one byte at a time, least significant byte of each word first.
// - within a byte, bits enter most significant first.
// - checksum input is 72 bits, bit 7 of current first, bit 16 last.
// - all sixteen state bits preset to one before the first input bit.
// - generator polynomial has coefficients 0, 5 and 12 plus x^16.
// - feedback is input xor bit 15; shift with polynomial taps for 72 steps.
// - final state stored in checksum register, state bit 0 as lsb.
// - rate 0 checksum covers same cycle samples, other rates the previous cycle.
// - checksum register readable singly and within the burst read.
// - setup bit 3 selects external input at 0 (reset) or temperature at 1.
// - two-channel variant always measures temperature, select bit ignored.
// - third converter result always lands in the second voltage sample register.
// - read-only 8-bit signed temperature trim word holds negated factory offset.
// - setup bit 7 resets to 0 for wide bandwidth, 1 selects narrow.
`timescale 1ns/1ps
module aoc_output_stage #(
    parameter FILT_W       = 28,
    parameter TWO_CHANNEL  = 0,
    parameter [7:0] TRIM_VALUE = 8'h00  // arbitrary factory trim for simulation
) (
    input  wire              clk,
    input  wire              reset_n,
    input  wire              clk_en,
    input  wire              input_clock,
    input  wire [FILT_W-1:0] filt_current,
    input  wire [FILT_W-1:0] filt_volt_one,
    input  wire [FILT_W-1:0] filt_volt_ext,
    input  wire [FILT_W-1:0] filt_temp,
    input  wire              setup_wr,
    input  wire [7:0]        setup_wdata,
    input  wire              rd_en,
    input  wire [3:0]        rd_addr,
    input  wire              burst_rd,
    input  wire [2:0]        burst_idx,
    output reg  [23:0]       rd_data,
    output reg               rd_err,
    output wire              temp_select_out,
    output wire              narrow_band_select,
    output wire [1:0]        output_rate_field,
    output reg               sample_strobe,
    output reg               crc_strobe
);
    `include "aoc_regs.vh"

    // ==========================================================
    // input clock synchroniser and edge finder
    // s1 may be metastable, so only s2 and the edge flop s3 feed any logic
    reg        iclk_s1_q;
    reg        iclk_s2_q;
    reg        iclk_s3_q;
    wire       iclk_rise;

    always @(posedge clk) begin
        if (!reset_n) begin
            iclk_s1_q <= 1'b0;
            iclk_s2_q <= 1'b0;
            iclk_s3_q <= 1'b0;
        end else if (clk_en) begin
            iclk_s1_q <= input_clock;
            iclk_s2_q <= iclk_s1_q;
            iclk_s3_q <= iclk_s2_q;
        end
    end
    assign iclk_rise = iclk_s2_q & ~iclk_s3_q;

    // ==========================================================
    // setup register
    reg [7:0] setup_q;
    always @(posedge clk) begin
        if (!reset_n)
            setup_q <= `AOC_SETUP_RESET;
        else if (clk_en && setup_wr)
            setup_q <= setup_wdata;
    end
    assign output_rate_field  = setup_q[`AOC_SETUP_RATE_HI:`AOC_SETUP_RATE_LO];
    assign narrow_band_select = setup_q[`AOC_SETUP_BW_BIT];
    // the two-channel part has no external second input, so the mux is forced
    assign temp_select_out    = (TWO_CHANNEL != 0) ? 1'b1 : setup_q[`AOC_SETUP_TEMP_BIT];

    // ==========================================================
    // output cycle divider in input clock periods
    reg  [12:0] div_q;
    reg  [12:0] div_len;
    wire        cycle_end;
    wire        div_last;

    always @* begin
        case (output_rate_field)
            2'h0:    div_len = `AOC_DIV_RATE0;
            2'h1:    div_len = `AOC_DIV_RATE1;
            2'h2:    div_len = `AOC_DIV_RATE2;
            default: div_len = `AOC_DIV_RATE3;
        endcase
    end
    // a rate write acts on the running cycle, so the first cycle after it is irregular
    assign div_last  = (div_q >= div_len - 13'h0001);
    assign cycle_end = iclk_rise && div_last;

    always @(posedge clk) begin
        if (!reset_n)
            div_q <= 13'h0000;
        else if (clk_en && iclk_rise) begin
            if (cycle_end)
                div_q <= 13'h0000;
            else
                div_q <= div_q + 13'h0001;
        end
    end

    // ==========================================================
    // clamp and latch samples
    wire [23:0] sat_cur;
    wire [23:0] sat_v1;
    wire [23:0] sat_v2;
    wire [FILT_W-1:0] third_src;

    // clamping ahead of the latch makes an overflow read as full scale, never wrapped
    assign third_src = temp_select_out ? filt_temp : filt_volt_ext;

    aoc_sat24 #(.IN_W(FILT_W)) u_sat_cur (.din(filt_current), .dout(sat_cur));
    aoc_sat24 #(.IN_W(FILT_W)) u_sat_v1  (.din(filt_volt_one), .dout(sat_v1));
    aoc_sat24 #(.IN_W(FILT_W)) u_sat_v2  (.din(third_src), .dout(sat_v2));

    reg [23:0] current_sample_q;
    reg [23:0] voltage_one_sample_q;
    reg [23:0] voltage_two_sample_q;

    always @(posedge clk) begin
        if (!reset_n) begin
            current_sample_q     <= 24'h000000;
            voltage_one_sample_q <= 24'h000000;
            voltage_two_sample_q <= 24'h000000;
            sample_strobe        <= 1'b0;
        end else if (clk_en) begin
            sample_strobe <= cycle_end;
            if (cycle_end) begin
                current_sample_q     <= sat_cur;
                voltage_one_sample_q <= sat_v1;
                voltage_two_sample_q <= sat_v2;
            end
        end
    end

    // ==========================================================
    // checksum engine: 72 serial steps
    // the snapshot decouples the engine from the next latch, so at slow rates the
    // published value lags one cycle while the fastest rate publishes the same cycle
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg         st_q;
    reg [71:0]  stream_q;
    reg [6:0]   step_q;
    reg [15:0]  lfsr_q;
    reg [15:0]  pend_q;
    reg         pend_vld_q;
    reg [15:0]  sample_checksum_q;
    wire [15:0] lfsr_next;
    wire [71:0] stream_init;
    wire [23:0] cur_bytes;
    wire [23:0] v1_bytes;
    wire [23:0] v2_bytes;
    wire        last_step;
    wire        fast_rate;
    wire        publish_now;

    // lsb byte of each word first, each byte msb first: reverse byte order per word
    assign cur_bytes   = {current_sample_q[7:0], current_sample_q[15:8],
                          current_sample_q[23:16]};
    assign v1_bytes    = {voltage_one_sample_q[7:0], voltage_one_sample_q[15:8],
                          voltage_one_sample_q[23:16]};
    assign v2_bytes    = {voltage_two_sample_q[7:0], voltage_two_sample_q[15:8],
                          voltage_two_sample_q[23:16]};
    // stream bit 71 goes in first: bit 7 of the current word
    assign stream_init = {cur_bytes, v1_bytes, v2_bytes};

    assign last_step   = (step_q == `AOC_CRC_STEPS - 7'h01);
    assign fast_rate   = (output_rate_field == 2'h0);
    // slow rates hold the result to the next boundary, the lag the host expects
    assign publish_now = pend_vld_q && (fast_rate || sample_strobe);

    aoc_crc_step u_step (
        .state_in  (lfsr_q),
        .bit_in    (stream_q[71]),
        .state_out (lfsr_next)
    );

    always @(posedge clk) begin
        if (!reset_n) begin
            st_q       <= ST_IDLE;
            stream_q   <= 72'h0;
            step_q     <= 7'h00;
            lfsr_q     <= `AOC_CRC_PRESET;
            pend_q     <= 16'h0000;
        end else if (clk_en) begin
            case (st_q)
                ST_IDLE: begin
                    if (sample_strobe) begin
                        stream_q <= stream_init;
                        lfsr_q   <= `AOC_CRC_PRESET;
                        step_q   <= 7'h00;
                        st_q     <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    lfsr_q   <= lfsr_next;
                    stream_q <= {stream_q[70:0], 1'b0};
                    step_q   <= step_q + 7'h01;
                    if (last_step) begin
                        pend_q <= lfsr_next;
                        st_q   <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // a finish and a publish never share an edge, but the set wins if they ever do
    always @(posedge clk) begin
        if (!reset_n)
            pend_vld_q <= 1'b0;
        else if (clk_en) begin
            if ((st_q == ST_RUN) && last_step)
                pend_vld_q <= 1'b1;
            else if (publish_now)
                pend_vld_q <= 1'b0;
        end
    end

    // rate 0 publishes as soon as done, others at the next cycle boundary
    always @(posedge clk) begin
        if (!reset_n) begin
            sample_checksum_q <= 16'h0000;
            crc_strobe        <= 1'b0;
        end else if (clk_en) begin
            crc_strobe <= 1'b0;
            if (publish_now) begin
                sample_checksum_q <= pend_q;
                crc_strobe        <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read port: single register reads and burst order
    // burst steps cover the sample words and checksum; trim and setup are single reads
    reg [3:0] eff_addr;
    always @* begin
        if (burst_rd) begin
            case (burst_idx)
                3'h0:    eff_addr = `AOC_OFS_CURRENT;
                3'h1:    eff_addr = `AOC_OFS_VOLT_ONE;
                3'h2:    eff_addr = `AOC_OFS_VOLT_TWO;
                3'h3:    eff_addr = `AOC_OFS_CHECKSUM;
                default: eff_addr = 4'hF;
            endcase
        end else
            eff_addr = rd_addr;
    end

    reg [23:0] rd_next;
    reg        rd_bad;
    always @* begin
        rd_next = 24'h000000;
        rd_bad  = 1'b0;
        case (eff_addr)
            `AOC_OFS_CURRENT:   rd_next = current_sample_q;
            `AOC_OFS_VOLT_ONE:  rd_next = voltage_one_sample_q;
            `AOC_OFS_VOLT_TWO:  rd_next = voltage_two_sample_q;
            `AOC_OFS_CHECKSUM:  rd_next = {8'h00, sample_checksum_q};
            `AOC_OFS_TEMP_TRIM: rd_next = {16'h0000, TRIM_VALUE};
            `AOC_OFS_SETUP:     rd_next = {16'h0000, setup_q};
            default:            rd_bad  = 1'b1;
        endcase
    end

    // word and error load on the same edge, so an answer is never half old
    always @(posedge clk) begin
        if (!reset_n) begin
            rd_data <= 24'h000000;
            rd_err  <= 1'b0;
        end else if (clk_en && (rd_en || burst_rd)) begin
            rd_data <= rd_next;
            rd_err  <= rd_bad;
        end
    end
endmodule // aoc_output_stage

// ===== hdl/aoc_regs.vh
// register offsets, field positions, reset values and timing counts of the sample output stage
`ifndef AOC_REGS_VH
`define AOC_REGS_VH

// ==========================================================
// register offsets on the internal read port
`define AOC_OFS_CURRENT     4'h0
`define AOC_OFS_VOLT_ONE    4'h1
`define AOC_OFS_VOLT_TWO    4'h2
`define AOC_OFS_CHECKSUM    4'h3
`define AOC_OFS_TEMP_TRIM   4'h4
`define AOC_OFS_SETUP       4'h5

// ==========================================================
// setup register fields
`define AOC_SETUP_TEMP_BIT  3
`define AOC_SETUP_RATE_LO   4
`define AOC_SETUP_RATE_HI   5
`define AOC_SETUP_BW_BIT    7
`define AOC_SETUP_RESET     8'h00

// ==========================================================
// sample limits and checksum constants
`define AOC_CODE_MAX        24'h7FFFFF
`define AOC_CODE_MIN        24'h800000
`define AOC_CRC_PRESET      16'hFFFF
`define AOC_CRC_POLY        16'h1021
`define AOC_CRC_STEPS       7'h48

// ==========================================================
// output cycle lengths in input clock periods
`define AOC_DIV_RATE0       13'h0200
`define AOC_DIV_RATE1       13'h0400
`define AOC_DIV_RATE2       13'h0800
`define AOC_DIV_RATE3       13'h1000

`endif

// ===== hdl/aoc_sat24.v
// clamps a wide signed filter result into the 24-bit signed code span
`timescale 1ns/1ps
module aoc_sat24 #(
    parameter IN_W = 28
) (
    input  wire [IN_W-1:0] din,
    output reg  [23:0]     dout
);
    `include "aoc_regs.vh"
    wire signed [IN_W-1:0] s_din = din;
    wire signed [IN_W-1:0] s_max = {{(IN_W-24){1'b0}}, `AOC_CODE_MAX};
    wire signed [IN_W-1:0] s_min = {{(IN_W-24){1'b1}}, `AOC_CODE_MIN};

    always @* begin
        if (s_din > s_max)
            dout = `AOC_CODE_MAX;
        else if (s_din < s_min)
            dout = `AOC_CODE_MIN;
        else
            dout = din[23:0];
    end
endmodule // aoc_sat24

// ===== hdl/aoc_crc_step.v
// one serial step of the ccitt checksum shift register
`timescale 1ns/1ps
module aoc_crc_step (
    input  wire [15:0] state_in,
    input  wire        bit_in,
    output wire [15:0] state_out
);
    `include "aoc_regs.vh"
    wire        fb;
    wire [15:0] poly;

    assign poly      = `AOC_CRC_POLY;
    assign fb        = bit_in ^ state_in[15];
    assign state_out = {state_in[14:0], 1'b0} ^ ({16{fb}} & poly);
endmodule // aoc_crc_step

// ===== tb/aoc_conv_model.sv
// converter-side model: free running input clock and fixed filter results
`timescale 1ns/1ps
module aoc_conv_model #(
    parameter HALF_NS = 400
) (
    output reg         input_clock,
    output wire [27:0] filt_current,
    output wire [27:0] filt_volt_one,
    output wire [27:0] filt_volt_ext,
    output wire [27:0] filt_temp
);
    // ==========================================================
    // voltage results beyond the 24-bit span so both clamp ends are hit; current and temperature fit inside
    assign filt_current  = 28'h0123456;
    assign filt_volt_one = 28'h7FFFFFF;
    assign filt_volt_ext = 28'h8000000;
    // only the settled temperature result is modelled; a host ignores the first 5 ms
    assign filt_temp     = 28'hFFFFFF0;
    initial begin
        input_clock = 1'b0;
        forever #(HALF_NS) input_clock = ~input_clock;
    end
endmodule // aoc_conv_model

// ===== tb/aoc_output_stage_asserts.sv
// port-level checks of the sample output stage
`timescale 1ns/1ps
module aoc_output_stage_asserts #(
    parameter TWO_CHANNEL = 0
) (
    input wire       clk,
    input wire       reset_n,
    input wire       clk_en,
    input wire       input_clock,
    input wire       setup_wr,
    input wire [7:0] setup_wdata,
    input wire       rd_en,
    input wire [3:0] rd_addr,
    input wire       rd_err,
    input wire       temp_select_out,
    input wire       narrow_band_select,
    input wire [1:0] output_rate_field,
    input wire       sample_strobe,
    input wire       crc_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    reg        ick_q;
    reg        seen_q;
    reg [12:0] rises_q;
    // ==========================================================
    // raw rise count; synchroniser delay cancels between strobes
    always @(posedge clk) begin
        ick_q <= input_clock;
        if (!reset_n || setup_wr || !clk_en)
            seen_q <= 1'b0;
        else if (sample_strobe)
            seen_q <= 1'b1;
        if (sample_strobe)
            rises_q <= {12'h000, input_clock & ~ick_q};
        else if (input_clock & ~ick_q)
            rises_q <= rises_q + 13'h0001;
    end
    a_read_unmapped: assert property (clk_en && rd_en && rd_addr > 4'h5 |=> rd_err)
        else $error("unmapped read not refused");
    a_read_mapped: assert property (clk_en && rd_en && rd_addr <= 4'h5 |=> !rd_err)
        else $error("mapped read refused");
    a_rate_write: assert property (setup_wr && clk_en |=>
        output_rate_field == $past(setup_wdata[5:4]))
        else $error("rate field not written");
    a_band_write: assert property (setup_wr && clk_en |=>
        narrow_band_select == $past(setup_wdata[7]))
        else $error("band bit not written");
    a_temp_write: assert property (setup_wr && clk_en |=>
        temp_select_out == (TWO_CHANNEL != 0 || $past(setup_wdata[3])))
        else $error("temperature select wrong");
    a_strobe_pulse: assert property ($rose(sample_strobe) |=> !sample_strobe [*8])
        else $error("sample strobe too long");
    a_cycle_len: assert property (sample_strobe && seen_q |->
        rises_q == (13'h0200 << output_rate_field))
        else $error("output cycle length wrong");
    a_crc_same: assert property (sample_strobe && output_rate_field == 2'b00 |->
        ##[70:80] crc_strobe)
        else $error("checksum not published in cycle");
    a_crc_prev: assert property (sample_strobe && seen_q && output_rate_field != 2'b00 |->
        ##[0:2] crc_strobe)
        else $error("previous checksum not published");
    a_freeze_hold: assert property (!clk_en |=>
        $stable(sample_strobe) && $stable(crc_strobe) && $stable(rd_err))
        else $error("state moved while clock enable low");
endmodule // aoc_output_stage_asserts

bind aoc_output_stage aoc_output_stage_asserts #(.TWO_CHANNEL(TWO_CHANNEL)) u_chk (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .input_clock(input_clock),
    .setup_wr(setup_wr),
    .setup_wdata(setup_wdata), .rd_en(rd_en), .rd_addr(rd_addr), .rd_err(rd_err),
    .temp_select_out(temp_select_out), .narrow_band_select(narrow_band_select),
    .output_rate_field(output_rate_field), .sample_strobe(sample_strobe),
    .crc_strobe(crc_strobe));

// ===== tb/test_adc_output_crc_and_temp_select.sv
// self-checking bench of the sample output stage
`timescale 1ns/1ps
module test_adc_output_crc_and_temp_select;
    reg         clk;
    reg         reset_n;
    reg         clk_en;
    reg         setup_wr;
    reg  [7:0]  setup_wdata;
    reg         rd_en;
    reg         burst_rd;
    reg  [3:0]  rd_addr;
    reg  [15:0] crc_a;
    wire [23:0] rd_data;
    wire [23:0] rd_data_two;
    wire        temp_sel_two;
    wire        rd_err, temp_sel, nb_sel, s_stb, c_stb, ick;
    wire [1:0]  rate;
    wire [27:0] f_cur, f_v1, f_ext, f_tmp;
    integer     err_total, check_count, n;

    aoc_conv_model u_conv (.input_clock(ick), .filt_current(f_cur), .filt_volt_one(f_v1),
        .filt_volt_ext(f_ext), .filt_temp(f_tmp));
    // trim value is arbitrary
    aoc_output_stage #(.TRIM_VALUE(8'hFB)) u_dut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .input_clock(ick),
        .filt_current(f_cur), .filt_volt_one(f_v1), .filt_volt_ext(f_ext), .filt_temp(f_tmp),
        .setup_wr(setup_wr), .setup_wdata(setup_wdata), .rd_en(rd_en), .rd_addr(rd_addr),
        .burst_rd(burst_rd), .burst_idx(rd_addr[2:0]), .rd_data(rd_data), .rd_err(rd_err),
        .temp_select_out(temp_sel), .narrow_band_select(nb_sel), .output_rate_field(rate),
        .sample_strobe(s_stb), .crc_strobe(c_stb));
    // two-channel variant: third converter fixed on the temperature sensor
    aoc_output_stage #(.TWO_CHANNEL(1), .TRIM_VALUE(8'hFB)) u_dut_two (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .input_clock(ick),
        .filt_current(f_cur), .filt_volt_one(f_v1), .filt_volt_ext(f_ext), .filt_temp(f_tmp),
        .setup_wr(setup_wr), .setup_wdata(setup_wdata), .rd_en(rd_en), .rd_addr(rd_addr),
        .burst_rd(burst_rd), .burst_idx(rd_addr[2:0]), .rd_data(rd_data_two), .rd_err(),
        .temp_select_out(temp_sel_two), .narrow_band_select(), .output_rate_field(),
        .sample_strobe(), .crc_strobe());

    // ==========================================================
    // helpers
    function [15:0] crc72(input [23:0] a, input [23:0] b, input [23:0] c);
        reg [71:0] s;
        integer    i;
        begin
            s = {a[7:0], a[15:8], a[23:16], b[7:0], b[15:8], b[23:16], c[7:0], c[15:8], c[23:16]};
            crc72 = 16'hFFFF;
            for (i = 71; i >= 0; i = i - 1)
                crc72 = {crc72[14:0], 1'b0} ^ ((s[i] ^ crc72[15]) ? 16'h1021 : 16'h0000);
        end
    endfunction
    task give_verdict;
        begin
            if (err_total == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task check(input [23:0] seen, input [23:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rd(input b, input [3:0] a, input [23:0] exp, input e);
        begin
            @(negedge clk);
            rd_en = ~b;
            burst_rd = b;
            rd_addr = a;
            @(negedge clk);
            rd_en = 1'b0;
            burst_rd = 1'b0;
            @(negedge clk);
            check(rd_data, exp);
            check({23'h0, rd_err}, {23'h0, e});
        end
    endtask
    task wr(input [7:0] v);
        begin
            @(negedge clk);
            setup_wr = 1'b1;
            setup_wdata = v;
            @(negedge clk);
            setup_wr = 1'b0;
        end
    endtask
    // bounded wait; n ends as cycles since the call
    task wait_stb(input sel);
        begin
            n = 0;
            do begin
                @(negedge clk);
                n = n + 1;
            end while (((sel ? c_stb : s_stb) !== 1'b1) && n < 40000);
            if (n >= 40000) begin
                err_total = err_total + 1;
                give_verdict;
            end
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // main sequence
    initial begin
        err_total = 0;
        check_count = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        setup_wr = 1'b0;
        setup_wdata = 8'h00;
        rd_en = 1'b0;
        burst_rd = 1'b0;
        rd_addr = 4'h0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        rd(1'b0, 4'h5, 24'h000000, 1'b0);
        check({23'h0, temp_sel_two}, 24'h000001);
        rd(1'b0, 4'h4, 24'h0000FB, 1'b0);
        // frozen by clock enable: the read is not taken and the old word stands
        clk_en = 1'b0;
        rd(1'b0, 4'hA, 24'h0000FB, 1'b0);
        clk_en = 1'b1;
        rd(1'b0, 4'hA, 24'h000000, 1'b1);
        wait_stb(1'b0);
        wait_stb(1'b0);
        check(n[23:0], 24'h001000);
        wait_stb(1'b1);
        crc_a = crc72(24'h123456, 24'h7FFFFF, 24'h800000);
        rd(1'b0, 4'h0, 24'h123456, 1'b0);
        rd(1'b0, 4'h1, 24'h7FFFFF, 1'b0);
        rd(1'b1, 4'h2, 24'h800000, 1'b0);
        check(rd_data_two, 24'hFFFFF0);
        rd(1'b0, 4'h3, {8'h00, crc_a}, 1'b0);
        rd(1'b1, 4'h3, {8'h00, crc_a}, 1'b0);
        wr(8'h98);
        rd(1'b0, 4'h5, 24'h000098, 1'b0);
        check({20'h0, rate, nb_sel, temp_sel}, 24'h000007);
        wait_stb(1'b0);
        wait_stb(1'b0);
        check(n[23:0], 24'h002000);
        rd(1'b0, 4'h2, 24'hFFFFF0, 1'b0);
        crc_a = crc72(24'h123456, 24'h7FFFFF, 24'hFFFFF0);
        wr(8'h90);
        wait_stb(1'b0);
        rd(1'b0, 4'h2, 24'h800000, 1'b0);
        check(rd_data_two, 24'hFFFFF0);
        // past the in-cycle checksum finish, so a same-cycle publish would show
        repeat (80) @(negedge clk);
        rd(1'b0, 4'h3, {8'h00, crc_a}, 1'b0);
        give_verdict;
    end
endmodule // test_adc_output_crc_and_temp_select
